// ### fcs_pkg.sv
/*
 * fcs_pkg: register offsets, field layout, codes, reset values and address
 * bounds shared by the flash control shadow register block.
 * assumes: an 8-bit special-function-register port with 12-bit addresses.
 */
`default_nettype none

package fcs_pkg;

	// register port geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [11:0] OFS_STAGING = 12'h0fd0;
	localparam logic [11:0] OFS_COMMIT_KEY = 12'h0fd1; // write side
	localparam logic [11:0] OFS_LIVE_VIEW = 12'h0fd1; // read side of the same address
	localparam logic [11:0] OFS_STANDBY = 12'h0fd2;

	// staging and shadow field layout
	localparam int UNLOCK_MSB = 7;
	localparam int UNLOCK_LSB = 5;
	localparam int BOOT_BIT = 4;
	localparam int WIN_MSB = 3;
	localparam int WIN_LSB = 2;
	localparam int ROMSEL_MSB = 1;
	localparam int ROMSEL_LSB = 0;

	// live view layout
	localparam int VIEW_FLAG_BIT = 5;
	localparam int VIEW_BOOT_BIT = 4;

	// standby register layout
	localparam int STANDBY_BIT = 0;

	// codes
	localparam logic [2:0] UNLOCK_DIS = 3'h2;
	localparam logic [2:0] UNLOCK_EN = 3'h5;
	localparam logic [7:0] COMMIT_KEY = 8'hd5;

	// window select codes
	localparam logic [1:0] WIN_STD = 2'h0;
	localparam logic [1:0] WIN_DATA_LOW = 2'h1;
	localparam logic [1:0] WIN_CODE_HIGH = 2'h2;
	localparam logic [1:0] WIN_CODE_LOW = 2'h3;

	// reset values
	localparam logic [7:0] STAGING_RST = 8'h40;
	localparam logic [7:0] SHADOW_RST = 8'h40;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// address bounds (16-bit cpu space)
	localparam logic [15:0] FLASH_LO = 16'h1000;
	localparam logic [15:0] FLASH_HI = 16'hffff;
	localparam logic [15:0] LOW_HI = 16'h7fff;
	localparam logic [15:0] HIGH_LO = 16'h8000;
	localparam logic [15:0] WIN_LO = 16'h9000;
	localparam logic [15:0] WIN_OFFSET = 16'h8000;
	localparam logic [15:0] BOOT_LO = 16'h1000;
	localparam logic [15:0] BOOT_DATA_HI = 16'h17ff;
	localparam logic [15:0] BOOT_CODE_SER_HI = 16'h1fff;
	localparam logic [15:0] RAM_LO = 16'h0040;
	localparam logic [15:0] RAM_HI = 16'h0fff;

	// all state of the main block
	typedef struct packed {
		logic [7:0] staging;
		logic [7:0] shadow;
		logic standby;
		logic active;
		logic [7:0] rdata;
		logic sreset;
	} fcs_state_t;

endpackage : fcs_pkg

`default_nettype wire

// ### fcs_range_chk.sv
/*
 * fcs_range_chk: flags an address inside a fixed inclusive range.
 * assumes: bounds given as parameters, lo not above hi.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_range_chk #(
	parameter logic [15:0] LO = 16'h0000,
	parameter logic [15:0] HI = 16'hffff
) (
	// address under test
	input wire logic [15:0] addr,
	// inside the range
	output logic hit
);

	// inclusive compare on both bounds
	assign hit = (addr >= LO) && (addr <= HI);

endmodule : fcs_range_chk

`default_nettype wire

// ### fcs_window_map.sv
/*
 * fcs_window_map: translates a cpu data-space address into a flash array
 * address under the live window select, and flags a boot rom hit.
 * assumes: live window control comes from the shadow register, boot rom control from its boot bit or serial mode.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_window_map (
	// data access
	input wire logic [15:0] data_addr,
	// live controls
	input wire logic [1:0] window_map_live,
	input wire logic boot_shown,
	// translation result
	output logic flash_hit,
	output logic flash_code,
	output logic [15:0] flash_addr,
	output logic boot_hit
);

	logic in_boot;
	logic in_low;
	logic in_high;
	logic in_win;

	// region decode
	assign in_boot = boot_shown && (data_addr >= fcs_pkg::BOOT_LO) && (data_addr <= fcs_pkg::BOOT_DATA_HI);
	assign in_low = (data_addr >= fcs_pkg::FLASH_LO) && (data_addr <= fcs_pkg::LOW_HI);
	assign in_high = data_addr >= fcs_pkg::HIGH_LO;
	assign in_win = data_addr >= fcs_pkg::WIN_LO;
	assign boot_hit = in_boot;

	// window translation of the upper half
	always_comb begin
		flash_hit = 1'b0;
		flash_code = 1'b0;
		flash_addr = data_addr;
		if (in_boot) begin
			flash_hit = 1'b0;
		end else if (in_low) begin
			flash_hit = 1'b1;
		end else begin
			unique case (window_map_live)
				fcs_pkg::WIN_STD: begin
					flash_hit = in_high;
				end
				fcs_pkg::WIN_DATA_LOW: begin
					flash_hit = in_win;
					flash_addr = data_addr - fcs_pkg::WIN_OFFSET;
				end
				fcs_pkg::WIN_CODE_HIGH: begin
					flash_hit = in_high;
					flash_code = 1'b1;
				end
				fcs_pkg::WIN_CODE_LOW: begin
					flash_hit = in_win;
					flash_code = 1'b1;
					flash_addr = data_addr - fcs_pkg::WIN_OFFSET;
				end
			endcase
		end
	end

endmodule : fcs_window_map

`default_nettype wire

// ### fcs_shadow_regs.sv
/*
 * fcs_shadow_regs: staging and live shadow control for the flash array,
 * commit key, live view monitor and ram-only standby control.
 * assumes: one clock, cpu strobes synchronous to it, the cpu presents the
 * address of the instruction now executing and one-cycle access strobes.
 */
// Operation
// - unlock 010 blocks, 101 permits commands
// - staging takes effect only on key D5
// - window 00 gives standard upper mapping
// - window 01 maps data low area up
// - window 10 maps code high area
// - window 11 maps code low area up
// - boot rom shown by bit, always serially
// - live view shows shadow fields
// - live flag set only for live 101
// - live view bits 7 and 6 zero
// - serial mode reads boot bit as one
// - key with staged 101 activates array
// - standby write accepted only from ram
// - unlock field resets to disable code
// - standby bit one enters flash standby
// - flash access in standby forces reset
// - standby register always reads zero
`timescale 1ns/1ps
`default_nettype none

module fcs_shadow_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	// operating mode
	input wire logic serial_mode,
	// cpu instruction fetch
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_strobe,
	// cpu data access
	input wire logic [15:0] data_addr,
	input wire logic data_rd_strobe,
	input wire logic data_wr_strobe,
	// flash array controls
	output logic cmd_enable,
	output logic flash_active,
	output logic flash_standby,
	output logic [1:0] window_map_live,
	output logic bootrom_map_live,
	output logic [1:0] rom_select_live,
	output logic [15:0] flash_addr,
	output logic flash_data_hit,
	output logic flash_code_sel,
	output logic bootrom_data_hit,
	output logic bootrom_fetch_hit,
	output logic standby_reset_req
);

	fcs_pkg::fcs_state_t st_q;
	fcs_pkg::fcs_state_t st_d;

	logic [2:0] live_unlock;
	logic unlock_live_flag;
	logic [7:0] live_view;
	logic [7:0] staging_view;
	logic wr_staging;
	logic wr_commit;
	logic wr_standby;
	logic fetch_in_ram;
	logic fetch_in_flash;
	logic fetch_boot_norm;
	logic fetch_boot_ser;
	logic fetch_flash_hit;
	logic data_flash_any;

	// live field extraction
	assign live_unlock = st_q.shadow[fcs_pkg::UNLOCK_MSB:fcs_pkg::UNLOCK_LSB];
	assign unlock_live_flag = live_unlock == fcs_pkg::UNLOCK_EN;
	assign cmd_enable = unlock_live_flag; // 010 and reserved codes block
	assign window_map_live = st_q.shadow[fcs_pkg::WIN_MSB:fcs_pkg::WIN_LSB];
	assign bootrom_map_live = st_q.shadow[fcs_pkg::BOOT_BIT] | serial_mode;
	assign rom_select_live = st_q.shadow[fcs_pkg::ROMSEL_MSB:fcs_pkg::ROMSEL_LSB];

	// live view and staging read images
	always_comb begin
		live_view = fcs_pkg::ZERO_BYTE; // bits 7 and 6 stay zero
		live_view[fcs_pkg::VIEW_FLAG_BIT] = unlock_live_flag;
		live_view[fcs_pkg::VIEW_BOOT_BIT] = bootrom_map_live; // reads one serially
		live_view[fcs_pkg::WIN_MSB:fcs_pkg::WIN_LSB] = window_map_live;
		live_view[fcs_pkg::ROMSEL_MSB:fcs_pkg::ROMSEL_LSB] = rom_select_live;
		staging_view = st_q.staging;
		staging_view[fcs_pkg::BOOT_BIT] = st_q.staging[fcs_pkg::BOOT_BIT] | serial_mode;
	end

	// write decode
	assign wr_staging = reg_we && (reg_addr == fcs_pkg::OFS_STAGING);
	assign wr_commit = reg_we && (reg_addr == fcs_pkg::OFS_COMMIT_KEY) && (reg_wdata == fcs_pkg::COMMIT_KEY);
	assign wr_standby = reg_we && (reg_addr == fcs_pkg::OFS_STANDBY);

	// fetch side region checks on the current instruction address
	fcs_range_chk #(
		.LO(fcs_pkg::RAM_LO),
		.HI(fcs_pkg::RAM_HI)
	) u_fetch_ram (
		.addr(fetch_addr),
		.hit(fetch_in_ram)
	);

	fcs_range_chk #(
		.LO(fcs_pkg::FLASH_LO),
		.HI(fcs_pkg::FLASH_HI)
	) u_fetch_flash (
		.addr(fetch_addr),
		.hit(fetch_in_flash)
	);

	fcs_range_chk #(
		.LO(fcs_pkg::BOOT_LO),
		.HI(fcs_pkg::BOOT_DATA_HI)
	) u_fetch_boot_norm (
		.addr(fetch_addr),
		.hit(fetch_boot_norm)
	);

	fcs_range_chk #(
		.LO(fcs_pkg::BOOT_LO),
		.HI(fcs_pkg::BOOT_CODE_SER_HI)
	) u_fetch_boot_ser (
		.addr(fetch_addr),
		.hit(fetch_boot_ser)
	);

	// serial mode shows the wider boot rom in code space
	assign bootrom_fetch_hit = serial_mode ? fetch_boot_ser : (bootrom_map_live && fetch_boot_norm);
	assign fetch_flash_hit = fetch_in_flash && !bootrom_fetch_hit;

	// data side window translation
	fcs_window_map u_window_map (
		.data_addr(data_addr),
		.window_map_live(window_map_live),
		.boot_shown(bootrom_map_live),
		.flash_hit(flash_data_hit),
		.flash_code(flash_code_sel),
		.flash_addr(flash_addr),
		.boot_hit(bootrom_data_hit)
	);

	assign data_flash_any = (data_rd_strobe || data_wr_strobe) && flash_data_hit;

	// next state
	always_comb begin
		st_d = st_q;
		st_d.rdata = fcs_pkg::ZERO_BYTE;
		st_d.sreset = 1'b0;
		// staging holds writes; boot bit is frozen in serial mode
		if (wr_staging) begin
			st_d.staging = reg_wdata; // held until committed
			if (serial_mode) begin
				st_d.staging[fcs_pkg::BOOT_BIT] = st_q.staging[fcs_pkg::BOOT_BIT];
			end
		end
		// commit key copies staging into the live shadow
		if (wr_commit) begin
			st_d.shadow = st_q.staging;
			st_d.active = st_q.staging[fcs_pkg::UNLOCK_MSB:fcs_pkg::UNLOCK_LSB] == fcs_pkg::UNLOCK_EN;
		end
		// standby bit only from code running in ram
		if (wr_standby && fetch_in_ram) begin
			st_d.standby = reg_wdata[fcs_pkg::STANDBY_BIT];
		end
		// any flash access while in standby requests a device reset
		if (st_q.standby && ((fetch_strobe && fetch_flash_hit) || data_flash_any)) begin
			st_d.sreset = 1'b1;
		end
		// read data, valid the cycle after the strobe
		if (reg_re) begin
			unique case (reg_addr)
				fcs_pkg::OFS_STAGING: st_d.rdata = staging_view;
				fcs_pkg::OFS_LIVE_VIEW: st_d.rdata = live_view;
				fcs_pkg::OFS_STANDBY: st_d.rdata = fcs_pkg::ZERO_BYTE;
				default: st_d.rdata = fcs_pkg::ZERO_BYTE;
			endcase
		end
	end

	// state register, unlock field resets to the disable code
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.staging <= fcs_pkg::STAGING_RST;
			st_q.shadow <= fcs_pkg::SHADOW_RST;
			st_q.standby <= 1'b0;
			st_q.active <= 1'b0;
			st_q.rdata <= fcs_pkg::ZERO_BYTE;
			st_q.sreset <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign reg_rdata = st_q.rdata;
	assign flash_active = st_q.active;
	assign flash_standby = st_q.standby;
	assign standby_reset_req = st_q.sreset;

endmodule : fcs_shadow_regs

`default_nettype wire

// ### fcs_shadow_regs_assertions.sv
/*
 * fcs_shadow_regs_chk: port assertions for the flash control shadow block.
 * assumes: bound to fcs_shadow_regs, one clock, reset_n async active low.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_shadow_regs_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	// cpu side
	input wire logic serial_mode,
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_strobe,
	// flash controls
	input wire logic cmd_enable,
	input wire logic flash_active,
	input wire logic flash_standby,
	input wire logic [1:0] window_map_live,
	input wire logic bootrom_map_live,
	input wire logic [1:0] rom_select_live,
	input wire logic standby_reset_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// commit key and staging steps
	sequence key_wr;
		reg_we && reg_addr == 12'h0fd1 && reg_wdata == 8'hd5;
	endsequence
	sequence stage_open;
		reg_we && reg_addr == 12'h0fd0 && reg_wdata[7:5] == 3'h5;
	endsequence

	// read data only in the cycle after a read
	rd_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 8'h00) else $error("idle read data");
	view_hi_a: assert property ($past(reg_re && reg_addr == 12'h0fd1) |-> reg_rdata[7:6] == 2'h0)
		else $error("view top bits");
	view_live_a: assert property ($past(reg_re && reg_addr == 12'h0fd1) |-> reg_rdata[5:0] ==
		{$past(cmd_enable), $past(bootrom_map_live), $past(window_map_live), $past(rom_select_live)})
		else $error("view fields");
	stb_read_a: assert property ($past(reg_re && reg_addr == 12'h0fd2) |-> reg_rdata == 8'h00)
		else $error("standby read");
	serial_boot_a: assert property ($past(serial_mode && reg_re && reg_addr == 12'h0fd1) |-> reg_rdata[4])
		else $error("serial boot");
	win_hold_a: assert property ($changed({window_map_live, rom_select_live}) |->
		$past(reg_we && reg_addr == 12'h0fd1 && reg_wdata == 8'hd5)) else $error("window moved");
	cmd_hold_a: assert property ($changed(cmd_enable) |->
		$past(reg_we && reg_addr == 12'h0fd1 && reg_wdata == 8'hd5)) else $error("cmd moved");
	open_seq_a: assert property (stage_open ##1 key_wr |=> cmd_enable && flash_active)
		else $error("no open");
	stb_ram_a: assert property ($rose(flash_standby) |-> $past(reg_we && reg_addr == 12'h0fd2 &&
		reg_wdata[0] && fetch_addr inside {[16'h0040:16'h0fff]})) else $error("standby source");
	stb_hit_a: assert property (flash_standby && fetch_strobe && fetch_addr >= 16'h8000 |=> standby_reset_req)
		else $error("no standby reset");
	req_cause_a: assert property (standby_reset_req |-> $past(flash_standby)) else $error("stray reset");
endmodule : fcs_shadow_regs_chk

bind fcs_shadow_regs fcs_shadow_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .serial_mode(serial_mode),
	.fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe), .cmd_enable(cmd_enable), .flash_active(flash_active),
	.flash_standby(flash_standby), .window_map_live(window_map_live), .bootrom_map_live(bootrom_map_live),
	.rom_select_live(rom_select_live), .standby_reset_req(standby_reset_req));

`default_nettype wire

// ### fcs_shadow_regs_bench.sv
/*
 * fcs_shadow_regs_bench: directed register, window and standby tests.
 * assumes: fcs_shadow_regs with its checker bound, 125 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fcs_shadow_regs_bench;
	logic clk, reset_n, reg_we, reg_re, serial_mode, fetch_strobe;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] fetch_addr, data_addr, flash_addr;
	logic cmd_enable, flash_active, flash_standby, flash_data_hit, flash_code_sel, standby_reset_req;
	logic data_rd_strobe, data_wr_strobe, bootrom_data_hit, bootrom_fetch_hit, bootrom_map_live;
	logic [1:0] window_map_live, rom_select_live;
	int errors, num_checks, cyc;

	// device under test, every port driven or watched
	fcs_shadow_regs u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .serial_mode(serial_mode),
		.fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe), .data_addr(data_addr),
		.data_rd_strobe(data_rd_strobe), .data_wr_strobe(data_wr_strobe), .cmd_enable(cmd_enable),
		.flash_active(flash_active), .flash_standby(flash_standby), .window_map_live(window_map_live),
		.bootrom_map_live(bootrom_map_live), .rom_select_live(rom_select_live), .flash_addr(flash_addr),
		.flash_data_hit(flash_data_hit), .flash_code_sel(flash_code_sel), .bootrom_data_hit(bootrom_data_hit),
		.bootrom_fetch_hit(bootrom_fetch_hit), .standby_reset_req(standby_reset_req));

	// verdict and end of run
	task automatic end_sim();
		if (errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	// compare and count
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one-cycle write, strobe left for the next access to drop
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		reg_re <= 1'b0;
		@(posedge clk);
	endtask : wr

	// read strobe, then data checked in the following cycle
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_we <= 1'b0;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 chk({10'h000, reg_rdata}, {10'h000, e});
		@(posedge clk);
	endtask : rd

	// idle cycle, settled afterwards
	task automatic nop();
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		@(posedge clk);
		#1;
	endtask : nop

	// clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 1000) begin
			errors++;
			end_sim();
		end
	end

	// main sequence
	initial begin
		errors = 0;
		num_checks = 0;
		cyc = 0;
		reset_n = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		serial_mode = 1'b0;
		fetch_addr = 16'h0100;
		fetch_strobe = 1'b0;
		data_addr = 16'h0000;
		data_rd_strobe = 1'b0;
		data_wr_strobe = 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(12'h0fd0, 8'h40);
		rd(12'h0fd1, 8'h00);
		// staged value waits for the right key
		wr(12'h0fd0, 8'hb4);
		nop();
		rd(12'h0fd1, 8'h00);
		rd(12'h0fd0, 8'hb4);
		wr(12'h0fd0, 8'hb4);
		wr(12'h0fd1, 8'hd5);
		rd(12'h0fd1, 8'h34);
		#1 chk({16'h0000, cmd_enable, flash_active}, 18'h0_0003);
		chk({13'h0000, window_map_live, bootrom_map_live, rom_select_live}, 18'h0_000c);
		// boot rom shown in both spaces by the live bit
		data_addr <= 16'h1400;
		fetch_addr <= 16'h1400;
		nop();
		chk({15'h0000, bootrom_fetch_hit, bootrom_data_hit, flash_data_hit}, 18'h0_0006);
		// every window code, upper probe then a gap probe
		for (int w = 0; w < 4; w++) begin
			wr(12'h0fd0, {3'h5, 1'b0, 2'(w), 2'h0});
			wr(12'h0fd1, 8'hd5);
			data_addr <= 16'hc000;
			nop();
			chk({flash_code_sel, flash_data_hit, flash_addr}, {w[1], 1'b1, w[0] ? 16'h4000 : 16'hc000});
			data_addr <= 16'h8800;
			@(posedge clk);
			#1 chk({17'h0_0000, flash_data_hit}, {17'h0_0000, !w[0]});
		end
		serial_mode <= 1'b1;
		fetch_addr <= 16'h1c00;
		data_addr <= 16'h1400;
		rd(12'h0fd1, 8'h3c);
		#1 chk({15'h0000, bootrom_fetch_hit, bootrom_data_hit, flash_data_hit}, 18'h0_0006);
		serial_mode <= 1'b0;
		nop();
		chk({15'h0000, bootrom_fetch_hit, bootrom_data_hit, flash_data_hit}, 18'h0_0001);
		// relock
		wr(12'h0fd0, 8'h40);
		wr(12'h0fd1, 8'hd5);
		rd(12'h0fd1, 8'h00);
		#1 chk({16'h0000, cmd_enable, flash_active}, 18'h0_0000);
		// standby from flash code is dropped, from ram it sticks
		fetch_addr <= 16'h8000;
		wr(12'h0fd2, 8'h01);
		nop();
		chk({17'h0_0000, flash_standby}, 18'h0_0000);
		fetch_addr <= 16'h0100;
		wr(12'h0fd2, 8'h01);
		rd(12'h0fd2, 8'h00);
		#1 chk({17'h0_0000, flash_standby}, 18'h0_0001);
		fetch_addr <= 16'h8000;
		fetch_strobe <= 1'b1;
		@(posedge clk);
		fetch_strobe <= 1'b0;
		#1 chk({17'h0_0000, standby_reset_req}, 18'h0_0001);
		// data read then data write to flash while in standby
		data_rd_strobe <= 1'b1;
		@(posedge clk);
		data_rd_strobe <= 1'b0;
		data_wr_strobe <= 1'b1;
		#1 chk({17'h0_0000, standby_reset_req}, 18'h0_0001);
		@(posedge clk);
		data_wr_strobe <= 1'b0;
		#1 chk({17'h0_0000, standby_reset_req}, 18'h0_0001);
		@(posedge clk);
		#1 chk({17'h0_0000, standby_reset_req}, 18'h0_0000);
		end_sim();
	end
endmodule : fcs_shadow_regs_bench

`default_nettype wire
